// ==== bench/rgs_term_src.sv ====
// Run terminal stand-in driven by the bench
`timescale 1ns/10ps
`default_nettype none
module rgs_term_src (
    input wire logic sys_clk,
    input wire logic want,
    output logic runTerminalPin
);
    // ----------------------------------------
    // Contact level lands between clock edges
    // ----------------------------------------
    initial runTerminalPin = 1'b0;
    always @(posedge sys_clk) begin
        runTerminalPin <= #3 want;
    end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the run guard, sleep and wake block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic want = 1'b0;
    logic terminalChannel = 1'b1;
    rgs_pkg::rgs_cfg_t cfg = '0;
    rgs_pkg::rgs_freq_t freq = '0;
    logic runTerminalPin, running, coastStop, decelStop, atLowerLimit;
    logic guardActive, sleeping, stopSpeedReached;
    logic [2:0] stateOut;
    logic [15:0] above;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    int seed = 77871;
    rgs_term_src i_src (.sys_clk(sys_clk), .want(want),
        .runTerminalPin(runTerminalPin));
    rgs_run_guard_sleep_wake #(.TICK_DIV(4)) i_dut (.sys_clk(sys_clk),
        .rstn(rstn), .runTerminalPin(runTerminalPin),
        .terminalChannel(terminalChannel), .cfg(cfg), .freq(freq),
        .running(running), .coastStop(coastStop), .decelStop(decelStop),
        .atLowerLimit(atLowerLimit), .guardActive(guardActive),
        .sleeping(sleeping), .stopSpeedReached(stopSpeedReached),
        .stateOut(stateOut));
    // ----------------------------------------
    // Clock and timeout
    // ----------------------------------------
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_state(input logic [2:0] code, input int lim);
        int k;
        k = 0;
        while (stateOut !== code && k < lim) begin
            step(1);
            k++;
        end
        check("stateOut", 16'(stateOut), 16'(code));
        check("running", 16'(running), 16'(code == 3'h3));
        check("sleeping", 16'(sleeping), 16'(code == 3'h4));
        check("guardActive", 16'(guardActive), 16'(code == 3'h1));
    endtask
    task automatic do_reset(input logic pin, input logic guard);
        rstn = 1'b0;
        want = pin;
        cfg.powerOnRunGuard = guard;
        step(16);
        rstn = 1'b1;
    endtask
    task automatic test_done();
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        cfg.stopSpeedQualifyTime = 16'h0001;
        cfg.wakeFromSleepDelay = 16'h0001;
        freq.lowerLimit = 16'h0100;
        freq.stopSpeed = 16'h0010;
        freq.measFreq = 16'h0100;
        above = 16'h0101 + 16'($random(seed) & 32'h00ff);
        freq.setFreq = above;
        do_reset(1'b1, 1'b0);
        wait_state(3'h1, 200);
        check("guardActive", 16'(guardActive), 16'h0001);
        check("running", 16'(running), 16'h0000);
        want = 1'b0;
        wait_state(3'h2, 20);
        want = 1'b1;
        wait_state(3'h3, 20);
        freq.setFreq = freq.lowerLimit;
        step(4);
        check("atLowerLimit", 16'(atLowerLimit), 16'h0001);
        check("running", 16'(running), 16'h0001);
        cfg.belowLimitActionSelect = 2'h2;
        wait_state(3'h4, 4);
        step(2);
        check("coastStop", 16'(coastStop), 16'h0001);
        check("decelStop", 16'(decelStop), 16'h0000);
        freq.setFreq = above;
        step(20);
        check("sleeping", 16'(sleeping), 16'h0001);
        freq.setFreq = freq.lowerLimit;
        step(2);
        freq.setFreq = above;
        step(30);
        check("sleeping", 16'(sleeping), 16'h0001);
        wait_state(3'h3, 60);
        cfg.wakeFromSleepDelay = 16'h0000;
        freq.setFreq = freq.lowerLimit;
        wait_state(3'h4, 4);
        freq.setFreq = above;
        wait_state(3'h3, 8);
        cfg.belowLimitActionSelect = 2'h1;
        freq.setFreq = freq.lowerLimit;
        wait_state(3'h2, 6);
        step(20);
        check("stopSpeedReached", 16'(stopSpeedReached), 16'h0001);
        cfg.stopSpeedSourceSelect = 1'b1;
        step(20);
        check("stopSpeedReached", 16'(stopSpeedReached), 16'h0000);
        check("decelStop", 16'(decelStop), 16'h0001);
        freq.measFreq = 16'h0008;
        step(20);
        check("stopSpeedReached", 16'(stopSpeedReached), 16'h0001);
        cfg.belowLimitActionSelect = 2'h0;
        do_reset(1'b1, 1'b1);
        wait_state(3'h3, 200);
        terminalChannel = 1'b0;
        wait_state(3'h2, 4);
        want = 1'b0;
        step(4);
        want = 1'b1;
        step(6);
        check("running", 16'(running), 16'h0000);
        test_done();
    end
endmodule
`default_nettype wire

// ==== design/rgs_map.svh ====
// Constants for the run guard, sleep and wake control block
`ifndef RGS_MAP_SVH
`define RGS_MAP_SVH
`define RGS_CLK_HZ 125000000
`define RGS_TICK_HZ 100
`define RGS_TICK_DIV (`RGS_CLK_HZ / `RGS_TICK_HZ)
`define RGS_QUAL_MAX_CS 16'h2710
`define RGS_QUAL_DEF_CS 16'h0032
`define RGS_WAKE_MAX_DS 16'h8ca0
`define RGS_WAKE_DEF_DS 16'h0000
`define RGS_DS_TICKS 4'ha
`define RGS_SRC_CMD 1'b0
`define RGS_SRC_MEAS 1'b1
`define RGS_GUARD_BLOCK 1'b0
`define RGS_GUARD_AUTO 1'b1
`define RGS_ACT_LIMIT 2'h0
`define RGS_ACT_STOP 2'h1
`define RGS_ACT_SLEEP 2'h2
`define RGS_INIT_TICKS 8'h0a
`endif

// ==== design/rgs_pkg.sv ====
// Types for the run guard, sleep and wake control block
`default_nettype none
package rgs_pkg;
    typedef enum logic [2:0] {
        RGS_INIT = 3'h0,
        RGS_GUARD = 3'h1,
        RGS_IDLE = 3'h2,
        RGS_RUN = 3'h3,
        RGS_SLEEP = 3'h4
    } rgs_state_t;
    typedef struct packed {
        logic stopSpeedSourceSelect;
        logic powerOnRunGuard;
        logic [1:0] belowLimitActionSelect;
        logic [15:0] stopSpeedQualifyTime;
        logic [15:0] wakeFromSleepDelay;
    } rgs_cfg_t;
    typedef struct packed {
        logic [15:0] setFreq;
        logic [15:0] measFreq;
        logic [15:0] cmdFreq;
        logic [15:0] lowerLimit;
        logic [15:0] stopSpeed;
    } rgs_freq_t;
endpackage
`default_nettype wire

// ==== design/rgs_run_guard_sleep_wake.sv ====
// Run guard, sleep and wake control of a motor drive
// Summary of operation
// - Source 0 uses commanded speed; sole choice under vector modulation.
// - Source 1 compares measured speed against the stop speed.
// - Stop speed qualify time 0.00 to 100.00 s, default 0.50 s.
// - Run terminal sampled automatically during power up before any run.
// - Guard 0: terminal high at power up ignored until dropped and raised.
// - Guard 1: terminal high at power up starts drive after initialization.
// - Below limit action: 0 run at limit, 1 stop, 2 sleep.
// - Sleep removes drive and coasts instead of controlled deceleration.
// - Sleep entered when set frequency at or below lower limit and sleep selected.
// - Wake only after set frequency stays above limit for the wake delay.
// - Wake delay defaults to zero seconds, waking at once.
// - Wake delay 0.0 to 3600.0 s, used only with sleep action.
`timescale 1ns/10ps
`default_nettype none
`include "rgs_map.svh"
module rgs_run_guard_sleep_wake #(
    parameter int TICK_DIV = `RGS_TICK_DIV
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic runTerminalPin,
    input wire logic terminalChannel,
    input wire rgs_pkg::rgs_cfg_t cfg,
    input wire rgs_pkg::rgs_freq_t freq,
    output logic running,
    output logic coastStop,
    output logic decelStop,
    output logic atLowerLimit,
    output logic guardActive,
    output logic sleeping,
    output logic stopSpeedReached,
    output logic [2:0] stateOut
);
// ---------------------------------------------
// Input synchroniser and tick divider
// ---------------------------------------------
logic runMeta_q, runSync_q, runPrev_q;
logic [31:0] divCnt_q, divCnt_d;
logic tick;
always_comb begin
    divCnt_d = (divCnt_q >= 32'(TICK_DIV - 1)) ? 32'h0 : divCnt_q + 32'h1;
end
assign tick = (divCnt_q >= 32'(TICK_DIV - 1));
always_ff @(posedge sys_clk) begin
    if (!rstn) begin
        runMeta_q <= 1'b0;
        runSync_q <= 1'b0;
        runPrev_q <= 1'b0;
        divCnt_q <= 32'h0;
    end else begin
        runMeta_q <= runTerminalPin;
        runSync_q <= runMeta_q;
        runPrev_q <= runSync_q;
        divCnt_q <= divCnt_d;
    end
end
// ---------------------------------------------
// Parameter clamping
// ---------------------------------------------
function automatic logic [15:0] clampVal(input logic [15:0] v,
                                         input logic [15:0] mx);
    clampVal = (v > mx) ? mx : v;
endfunction
logic [15:0] qualLimit, wakeLimit;
logic [19:0] wakeTicks;
assign qualLimit = clampVal(cfg.stopSpeedQualifyTime,
    `RGS_QUAL_MAX_CS);
assign wakeLimit = clampVal(cfg.wakeFromSleepDelay, `RGS_WAKE_MAX_DS);
assign wakeTicks = 20'(wakeLimit) * 20'(`RGS_DS_TICKS);
// ---------------------------------------------
// Stop speed detection
// ---------------------------------------------
logic [15:0] stopSrc;
logic belowStop;
logic [15:0] qualCnt_q, qualCnt_d;
logic reached_q, reached_d;
always_comb begin
    stopSrc = (cfg.stopSpeedSourceSelect == `RGS_SRC_MEAS) ?
        freq.measFreq : freq.cmdFreq;
    belowStop = (stopSrc <= freq.stopSpeed);
    qualCnt_d = qualCnt_q;
    reached_d = reached_q;
    if (!belowStop) begin
        qualCnt_d = 16'h0;
        reached_d = 1'b0;
    end else if (qualCnt_q >= qualLimit) begin
        reached_d = 1'b1;
    end else if (tick) begin
        qualCnt_d = qualCnt_q + 16'h1;
    end
end
// ---------------------------------------------
// Run state machine
// ---------------------------------------------
rgs_pkg::rgs_state_t state_q, state_d;
logic [7:0] initCnt_q, initCnt_d;
logic startSeen_q, startSeen_d;
logic [19:0] wakeCnt_q, wakeCnt_d;
logic runReq, runRise, setBelow, actSleep;
assign runReq = runSync_q && terminalChannel;
assign runRise = runSync_q && !runPrev_q && terminalChannel;
assign setBelow = (freq.setFreq <= freq.lowerLimit);
assign actSleep = (cfg.belowLimitActionSelect == `RGS_ACT_SLEEP);
always_comb begin
    state_d = state_q;
    initCnt_d = initCnt_q;
    startSeen_d = startSeen_q;
    wakeCnt_d = 20'h0;
    case (state_q)
        rgs_pkg::RGS_INIT: begin
            startSeen_d = runReq;
            if (tick) begin
                initCnt_d = initCnt_q + 8'h1;
            end
            if (initCnt_q >= `RGS_INIT_TICKS) begin
                if (!startSeen_q) begin
                    state_d = rgs_pkg::RGS_IDLE;
                end else if (cfg.powerOnRunGuard == `RGS_GUARD_AUTO) begin
                    state_d = rgs_pkg::RGS_RUN;
                end else begin
                    state_d = rgs_pkg::RGS_GUARD;
                end
            end
        end
        rgs_pkg::RGS_GUARD: begin
            if (!runReq) begin
                state_d = rgs_pkg::RGS_IDLE;
            end
        end
        rgs_pkg::RGS_IDLE: begin
            if (runRise) begin
                state_d = rgs_pkg::RGS_RUN;
            end
        end
        rgs_pkg::RGS_RUN: begin
            if (!runReq) begin
                state_d = rgs_pkg::RGS_IDLE;
            end else if (setBelow && actSleep) begin
                state_d = rgs_pkg::RGS_SLEEP;
            end else if (setBelow &&
                         cfg.belowLimitActionSelect == `RGS_ACT_STOP) begin
                state_d = rgs_pkg::RGS_IDLE;
            end
        end
        rgs_pkg::RGS_SLEEP: begin
            if (!runReq || !actSleep) begin
                state_d = rgs_pkg::RGS_IDLE;
            end else if (setBelow) begin
                wakeCnt_d = 20'h0;
            end else if (wakeCnt_q >= wakeTicks) begin
                state_d = rgs_pkg::RGS_RUN;
            end else begin
                wakeCnt_d = tick ? wakeCnt_q + 20'h1 : wakeCnt_q;
            end
        end
        default: begin
            state_d = rgs_pkg::RGS_INIT;
        end
    endcase
end
always_ff @(posedge sys_clk) begin
    if (!rstn) begin
        state_q <= rgs_pkg::RGS_INIT;
        initCnt_q <= 8'h0;
        startSeen_q <= 1'b0;
        wakeCnt_q <= 20'h0;
        qualCnt_q <= 16'h0;
        reached_q <= 1'b0;
    end else begin
        state_q <= state_d;
        initCnt_q <= initCnt_d;
        startSeen_q <= startSeen_d;
        wakeCnt_q <= wakeCnt_d;
        qualCnt_q <= qualCnt_d;
        reached_q <= reached_d;
    end
end
// ---------------------------------------------
// Outputs
// ---------------------------------------------
logic lim_q, coast_q, decel_q;
logic lim_d, coast_d, decel_d;
always_comb begin
    lim_d = (state_q == rgs_pkg::RGS_RUN) && setBelow &&
        cfg.belowLimitActionSelect == `RGS_ACT_LIMIT;
    coast_d = (state_q == rgs_pkg::RGS_SLEEP);
    decel_d = (state_q == rgs_pkg::RGS_IDLE) && !reached_q;
end
always_ff @(posedge sys_clk) begin
    if (!rstn) begin
        lim_q <= 1'b0;
        coast_q <= 1'b0;
        decel_q <= 1'b0;
    end else begin
        lim_q <= lim_d;
        coast_q <= coast_d;
        decel_q <= decel_d;
    end
end
assign running = (state_q == rgs_pkg::RGS_RUN);
assign guardActive = (state_q == rgs_pkg::RGS_GUARD);
assign sleeping = (state_q == rgs_pkg::RGS_SLEEP);
assign atLowerLimit = lim_q;
assign coastStop = coast_q;
assign decelStop = decel_q;
assign stopSpeedReached = reached_q;
assign stateOut = state_q;
// ---------------------------------------------
// Checks
// ---------------------------------------------
chk_guard_holds: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    state_q == rgs_pkg::RGS_GUARD |=> state_q != rgs_pkg::RGS_RUN)
    else $error("guard went straight to run");
chk_auto_start: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    state_q == rgs_pkg::RGS_INIT && state_d != rgs_pkg::RGS_INIT &&
    startSeen_q && cfg.powerOnRunGuard |=> running)
    else $error("auto start missed");
chk_sleep_entry: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    running && runReq && setBelow && actSleep |=> sleeping)
    else $error("sleep not entered");
chk_coast_out: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    sleeping |=> coastStop)
    else $error("no coast in sleep");
chk_wake_delay: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $past(sleeping) && running |-> $past(wakeCnt_q) >= $past(wakeTicks))
    else $error("woke early");
chk_wake_reset: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    sleeping && setBelow |=> wakeCnt_q == 20'h0)
    else $error("wake timer kept");
chk_stop_action: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    running && runReq && setBelow &&
    cfg.belowLimitActionSelect == `RGS_ACT_STOP |=> !running)
    else $error("stop action ignored");
chk_stop_source: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    stopSpeedReached |-> $past(belowStop))
    else $error("stop speed flag wrong");
endmodule
`default_nettype wire
